// >>> hw/sspr_regs.sv
`timescale 1ns/1ps
`include "sspr_consts.svh"

module sspr_regs
  import sspr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FIFO_DEPTH = 16,
  // arbitrary neutral value, not a real part code
  parameter logic [31:0] IDENT_WORD = 32'h0000_0A5A,
  // arbitrary neutral value, not a real version code
  parameter logic [31:0] VERSION_WORD = 32'h0000_0001
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // serial core state, same clock
  input wire logic [7:0] tx_fill_count_in,
  input wire logic [7:0] rx_fill_count_in,
  input wire logic core_busy_in,
  input wire logic collision_error_in,
  input wire logic transmission_error_in,
  input wire logic tx_overflow_evt_in,
  input wire logic rx_overflow_evt_in,
  input wire logic rx_underflow_evt_in,
  input wire logic contention_evt_in,
  // serial link clock as seen on the pin
  input wire logic link_clk_in,
  // outputs
  output logic sclk_out,
  output logic irq_out,
  output logic tx_dma_req_out,
  output logic rx_dma_req_out
);

  // fill counts are eight bits wide; decode needs a full address byte
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > 255) begin : g_depth_chk
    $error("FIFO_DEPTH must be 1 to 255");
  end
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_chk
    $error("ADDR_W must be 8 to 32");
  end

  localparam logic [7:0] DEPTH_B = 8'(FIFO_DEPTH);
  localparam logic [7:0] IDLE_CYC = 8'(`SSPR_LINK_IDLE_CYC);
  localparam logic [7:0] OFF_FIRST = `SSPR_OFF_CLK_DIV;
  localparam logic [7:0] OFF_LAST = `SSPR_OFF_VERSION;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // word-aligned offset match, low two address bits ignored
  function automatic logic at_off(input logic [ADDR_W-1:0] addr,
                                  input logic [7:0] off);
    return (addr[7:2] == off[7:2]) && ((32'(addr) >> 8) == 32'h00000000);
  endfunction

  // software-written state
  logic [15:0] clk_div_reg;
  logic [7:0] tx_thr_reg;
  logic [7:0] rx_thr_reg;
  sspr_irq_vec_type irq_mask_reg;
  logic [1:0] dma_ctrl_reg;
  logic [7:0] dma_txwm_reg;
  logic [7:0] dma_rxwm_reg;

  // bus channel state
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // interrupt and status state
  logic tx_ovf_reg;
  logic rx_ovf_reg;
  logic rx_unf_reg;
  logic contention_reg;
  logic irq_reg;
  logic [6:0] status_reg;
  logic tx_dma_reg;
  logic rx_dma_reg;

  // link clock sampling and divider
  logic link_s1_reg;
  logic link_s2_reg;
  logic link_s3_reg;
  logic [7:0] link_idle_reg;
  logic [15:0] div_cnt_reg;
  logic sclk_reg;

  // bus handshakes
  wire aw_take = s_axi_awvalid_in && awready_reg;
  wire w_take = s_axi_wvalid_in && wready_reg;
  wire ar_take = s_axi_arvalid_in && arready_reg;
  wire b_done = bvalid_reg && s_axi_bready_in;
  wire r_done = rvalid_reg && s_axi_rready_in;
  // both halves held and response slot free
  wire wr_go = !awready_reg && !wready_reg && !bvalid_reg;

  // write decode
  wire wr_div = wr_go && at_off(waddr_reg, `SSPR_OFF_CLK_DIV);
  wire wr_txthr = wr_go && at_off(waddr_reg, `SSPR_OFF_TX_THR);
  wire wr_rxthr = wr_go && at_off(waddr_reg, `SSPR_OFF_RX_THR);
  wire wr_mask = wr_go && at_off(waddr_reg, `SSPR_OFF_IRQ_MASK);
  wire wr_dma = wr_go && at_off(waddr_reg, `SSPR_OFF_DMA_CTRL);
  wire wr_txwm = wr_go && at_off(waddr_reg, `SSPR_OFF_DMA_TXWM);
  wire wr_rxwm = wr_go && at_off(waddr_reg, `SSPR_OFF_DMA_RXWM);

  // read decode on the address as taken
  wire [ADDR_W-1:0] ra = s_axi_araddr_in;
  wire rd_div = at_off(ra, `SSPR_OFF_CLK_DIV);
  wire rd_txthr = at_off(ra, `SSPR_OFF_TX_THR);
  wire rd_rxthr = at_off(ra, `SSPR_OFF_RX_THR);
  wire rd_txlvl = at_off(ra, `SSPR_OFF_TX_LVL);
  wire rd_rxlvl = at_off(ra, `SSPR_OFF_RX_LVL);
  wire rd_stat = at_off(ra, `SSPR_OFF_STATUS);
  wire rd_mask = at_off(ra, `SSPR_OFF_IRQ_MASK);
  wire rd_mstat = at_off(ra, `SSPR_OFF_IRQ_MSTAT);
  wire rd_raw = at_off(ra, `SSPR_OFF_IRQ_RAW);
  wire rd_txo = at_off(ra, `SSPR_OFF_TXO_ACK);
  wire rd_rxo = at_off(ra, `SSPR_OFF_RXO_ACK);
  wire rd_rxu = at_off(ra, `SSPR_OFF_RXU_ACK);
  wire rd_cont = at_off(ra, `SSPR_OFF_CONT_ACK);
  wire rd_all = at_off(ra, `SSPR_OFF_ALL_ACK);
  wire rd_dma = at_off(ra, `SSPR_OFF_DMA_CTRL);
  wire rd_txwm = at_off(ra, `SSPR_OFF_DMA_TXWM);
  wire rd_rxwm = at_off(ra, `SSPR_OFF_DMA_RXWM);
  wire rd_id = at_off(ra, `SSPR_OFF_IDENT);
  wire rd_ver = at_off(ra, `SSPR_OFF_VERSION);
  wire rd_hit = rd_div | rd_txthr | rd_rxthr | rd_txlvl | rd_rxlvl |
                rd_stat | rd_mask | rd_mstat | rd_raw | rd_txo | rd_rxo |
                rd_rxu | rd_cont | rd_all | rd_dma | rd_txwm | rd_rxwm |
                rd_id | rd_ver;
  // writes accepted from the divider up to the version word
  wire wr_hit = ((32'(waddr_reg) >> 8) == 32'h00000000) &&
                (waddr_reg[7:2] >= OFF_FIRST[7:2]) &&
                (waddr_reg[7:2] <= OFF_LAST[7:2]);

  // raw interrupt sources: two fifo levels, four sticky events
  // tx empty level irq
  wire tx_empty_raw = tx_fill_count_in <= tx_thr_reg;
  wire rx_full_raw = {1'b0, rx_fill_count_in} >= {1'b0, rx_thr_reg} + 9'h001;
  sspr_irq_vec_type irq_raw;
  assign irq_raw = {contention_reg, rx_full_raw, rx_ovf_reg, rx_unf_reg,
                    tx_ovf_reg, tx_empty_raw};
  sspr_irq_vec_type irq_masked;
  assign irq_masked = irq_raw & irq_mask_reg;

  // read-to-clear strobes, taken on the read address handshake
  // tx overflow ack
  wire clr_txo = ar_take && (rd_txo || rd_all);
  wire clr_rxo = ar_take && (rd_rxo || rd_all);
  wire clr_rxu = ar_take && (rd_rxu || rd_all);
  wire clr_cont = ar_take && (rd_cont || rd_all);
  wire any_clearable = tx_ovf_reg | rx_ovf_reg | rx_unf_reg | contention_reg;

  // link clock seen toggling keeps the busy flag up
  wire link_edge = link_s2_reg != link_s3_reg;
  wire link_active = link_idle_reg != 8'h00;

  // status word, registered, so it trails the live fill counts read at the level offsets by one cycle
  logic [6:0] status_next;
  assign status_next = {collision_error_in, transmission_error_in,
                        rx_fill_count_in == DEPTH_B,
                        rx_fill_count_in != 8'h00,
                        tx_fill_count_in == 8'h00,
                        tx_fill_count_in < DEPTH_B,
                        core_busy_in | link_active};

  // dma requests
  // tx dma at watermark
  wire tx_dma_next = dma_ctrl_reg[`SSPR_DMA_TX_EN] &&
                     (tx_fill_count_in <= dma_txwm_reg);
  // rx dma at watermark plus one
  wire rx_dma_next = dma_ctrl_reg[`SSPR_DMA_RX_EN] &&
                     ({1'b0, rx_fill_count_in} >= {1'b0, dma_rxwm_reg} + 9'h001);

  // read data mux, and-or over the one-hot decode
  wire [31:0] rd_data_w =
    ({32{rd_div}} & {16'h0000, clk_div_reg}) |
    ({32{rd_txthr}} & {24'h000000, tx_thr_reg}) |
    ({32{rd_rxthr}} & {24'h000000, rx_thr_reg}) |
    ({32{rd_txlvl}} & {24'h000000, tx_fill_count_in}) |
    ({32{rd_rxlvl}} & {24'h000000, rx_fill_count_in}) |
    ({32{rd_stat}} & {25'h0000000, status_reg}) |
    ({32{rd_mask}} & {26'h0000000, irq_mask_reg}) |
    ({32{rd_mstat}} & {26'h0000000, irq_masked}) |
    ({32{rd_raw}} & {26'h0000000, irq_raw}) |
    ({32{rd_txo}} & {31'h00000000, tx_ovf_reg}) |
    ({32{rd_rxo}} & {31'h00000000, rx_ovf_reg}) |
    ({32{rd_rxu}} & {31'h00000000, rx_unf_reg}) |
    ({32{rd_cont}} & {31'h00000000, contention_reg}) |
    ({32{rd_all}} & {31'h00000000, any_clearable}) |
    ({32{rd_dma}} & {30'h00000000, dma_ctrl_reg}) |
    ({32{rd_txwm}} & {24'h000000, dma_txwm_reg}) |
    ({32{rd_rxwm}} & {24'h000000, dma_rxwm_reg}) |
    ({32{rd_id}} & IDENT_WORD) |
    ({32{rd_ver}} & VERSION_WORD);

  // merged write data for each register
  wire [31:0] wmerge_div = merge_strb({16'h0000, clk_div_reg}, wdata_reg,
                                      wstrb_reg);
  wire [31:0] wmerge_lo = merge_strb(32'h00000000, wdata_reg, wstrb_reg);

  // write address and data channels, taken in either order
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      waddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        awready_reg <= 1'b0;
        waddr_reg <= s_axi_awaddr_in;
      end else if (b_done) begin
        awready_reg <= 1'b1;
      end
      if (w_take) begin
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end else if (b_done) begin
        wready_reg <= 1'b1;
      end
    end
  end

  // write response; read-only offsets accept and ignore data
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `SSPR_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `SSPR_RESP_OKAY : `SSPR_RESP_SLVERR;
    end else if (b_done) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel: data captured at the address handshake
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SSPR_RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_hit ? rd_data_w : 32'h00000000;
      rresp_reg <= rd_hit ? `SSPR_RESP_OKAY : `SSPR_RESP_SLVERR;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_div_reg <= `SSPR_RST_CLK_DIV;
      tx_thr_reg <= `SSPR_RST_BYTE;
      rx_thr_reg <= `SSPR_RST_BYTE;
      irq_mask_reg <= `SSPR_RST_IRQ;
      dma_ctrl_reg <= `SSPR_RST_DMA;
      dma_txwm_reg <= `SSPR_RST_BYTE;
      dma_rxwm_reg <= `SSPR_RST_BYTE;
    end else begin
      if (wr_div) clk_div_reg <= wmerge_div[15:0];
      if (wr_txthr && wstrb_reg[0]) tx_thr_reg <= wmerge_lo[7:0];
      if (wr_rxthr && wstrb_reg[0]) rx_thr_reg <= wmerge_lo[7:0];
      // mask write, only lane 0 matters
      if (wr_mask && wstrb_reg[0]) irq_mask_reg <= wmerge_lo[5:0];
      if (wr_dma && wstrb_reg[0]) dma_ctrl_reg <= wmerge_lo[1:0];
      if (wr_txwm && wstrb_reg[0]) dma_txwm_reg <= wmerge_lo[7:0];
      if (wr_rxwm && wstrb_reg[0]) dma_rxwm_reg <= wmerge_lo[7:0];
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_ovf_reg <= 1'b0;
      rx_ovf_reg <= 1'b0;
      rx_unf_reg <= 1'b0;
      contention_reg <= 1'b0;
    end else begin
      tx_ovf_reg <= (tx_ovf_reg && !clr_txo) || tx_overflow_evt_in;
      rx_ovf_reg <= (rx_ovf_reg && !clr_rxo) || rx_overflow_evt_in;
      rx_unf_reg <= (rx_unf_reg && !clr_rxu) || rx_underflow_evt_in;
      contention_reg <= (contention_reg && !clr_cont) || contention_evt_in;
    end
  end

  // registered outputs of status, interrupt and dma logic
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg <= 7'h00;
      irq_reg <= 1'b0;
      tx_dma_reg <= 1'b0;
      rx_dma_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      // irq is or of masked bits
      irq_reg <= |irq_masked;
      tx_dma_reg <= tx_dma_next;
      rx_dma_reg <= rx_dma_next;
    end
  end

  // link clock synchroniser; only stages two and three are compared
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_s1_reg <= 1'b0;
      link_s2_reg <= 1'b0;
      link_s3_reg <= 1'b0;
    end else begin
      link_s1_reg <= link_clk_in;
      link_s2_reg <= link_s1_reg;
      link_s3_reg <= link_s2_reg;
    end
  end

  // activity window; the link clock may stop between frames
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_idle_reg <= 8'h00;
    end else if (link_edge) begin
      link_idle_reg <= IDLE_CYC;
    end else if (link_active) begin
      link_idle_reg <= link_idle_reg - 8'h01;
    end
  end

  // serial clock: half period of divisor/2 cycles, divisor below 2 stops it
  wire [15:0] half_div = {1'b0, clk_div_reg[15:1]};
  wire div_run = clk_div_reg > 16'h0001;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_reg <= 16'h0000;
      sclk_reg <= 1'b0;
    end else if (!div_run) begin
      div_cnt_reg <= 16'h0000;
      sclk_reg <= 1'b0;
    end else if (div_cnt_reg >= half_div - 16'h0001) begin
      div_cnt_reg <= 16'h0000;
      sclk_reg <= !sclk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // every output straight from a flop
  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign irq_out = irq_reg;
  assign tx_dma_req_out = tx_dma_reg;
  assign rx_dma_req_out = rx_dma_reg;
  assign sclk_out = sclk_reg;

endmodule // sspr_regs

// >>> hw/sspr_consts.svh
`ifndef SSPR_CONSTS_SVH
`define SSPR_CONSTS_SVH

// register byte offsets
`define SSPR_OFF_CLK_DIV 8'h14
`define SSPR_OFF_TX_THR 8'h18
`define SSPR_OFF_RX_THR 8'h1C
`define SSPR_OFF_TX_LVL 8'h20
`define SSPR_OFF_RX_LVL 8'h24
`define SSPR_OFF_STATUS 8'h28
`define SSPR_OFF_IRQ_MASK 8'h2C
`define SSPR_OFF_IRQ_MSTAT 8'h30
`define SSPR_OFF_IRQ_RAW 8'h34
`define SSPR_OFF_TXO_ACK 8'h38
`define SSPR_OFF_RXO_ACK 8'h3C
`define SSPR_OFF_RXU_ACK 8'h40
`define SSPR_OFF_CONT_ACK 8'h44
`define SSPR_OFF_ALL_ACK 8'h48
`define SSPR_OFF_DMA_CTRL 8'h4C
`define SSPR_OFF_DMA_TXWM 8'h50
`define SSPR_OFF_DMA_RXWM 8'h54
`define SSPR_OFF_IDENT 8'h58
`define SSPR_OFF_VERSION 8'h5C

// status word bit positions
`define SSPR_ST_BUSY 0
`define SSPR_ST_TX_SPACE 1
`define SSPR_ST_TX_EMPTY 2
`define SSPR_ST_RX_NONEMPTY 3
`define SSPR_ST_RX_FULL 4
`define SSPR_ST_TX_ERR 5
`define SSPR_ST_COLLISION 6

// interrupt bit positions, shared by mask, masked and raw words
`define SSPR_IRQ_TX_EMPTY 0
`define SSPR_IRQ_TX_OVF 1
`define SSPR_IRQ_RX_UNF 2
`define SSPR_IRQ_RX_OVF 3
`define SSPR_IRQ_RX_FULL 4
`define SSPR_IRQ_CONTENTION 5

// dma control bit positions
`define SSPR_DMA_RX_EN 0
`define SSPR_DMA_TX_EN 1

// reset values
`define SSPR_RST_CLK_DIV 16'h0000
`define SSPR_RST_BYTE 8'h00
`define SSPR_RST_IRQ 6'h00
`define SSPR_RST_DMA 2'h0

// bus responses
`define SSPR_RESP_OKAY 2'h0
`define SSPR_RESP_SLVERR 2'h2

// timing
`define SSPR_CLK_PERIOD_NS 10
`define SSPR_LINK_IDLE_NS 320
`define SSPR_LINK_IDLE_CYC (`SSPR_LINK_IDLE_NS / `SSPR_CLK_PERIOD_NS)

`endif

// >>> hw/sspr_pkg.sv
package sspr_pkg;
  typedef logic [5:0] sspr_irq_vec_type;
  typedef logic [7:0] sspr_level_type;
  typedef logic [31:0] sspr_word_type;
endpackage

// >>> bench/sspr_regs_chk.sv
`timescale 1ns/1ps
`include "sspr_consts.svh"
module sspr_chk #(
  parameter int ADDR_W = 8,
  parameter logic [31:0] IDENT_WORD = 32'h0000_0A5A
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [7:0] tx_fill_count_in,
  input wire logic [7:0] rx_fill_count_in,
  input wire logic core_busy_in,
  input wire logic rx_dma_req_out
);
  // handshake strobes shared by the properties
  wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
  wire st_rd = ar_hs && s_axi_araddr_in == `SSPR_OFF_STATUS;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  rd_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read answer dropped early");
  rd_lat_a: assert property (ar_hs |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer late");
  wr_lat_a: assert property (aw_hs && w_hs |-> ##[1:2] s_axi_bvalid_out)
    else $error("write response late");
  unmap_rd_a: assert property (ar_hs && s_axi_araddr_in > 8'h5F
    |=> s_axi_rresp_out == `SSPR_RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  ident_rd_a: assert property (ar_hs &&
    s_axi_araddr_in == `SSPR_OFF_IDENT |=> s_axi_rdata_out == IDENT_WORD)
    else $error("identity word wrong");
  tx_level_a: assert property (ar_hs &&
    s_axi_araddr_in == `SSPR_OFF_TX_LVL && $stable(tx_fill_count_in)
    |=> s_axi_rdata_out == {24'h0, $past(tx_fill_count_in)})
    else $error("tx level readback wrong");
  rx_nonempty_a: assert property (st_rd && $stable(rx_fill_count_in)
    && $past(rst_n_in)
    |=> s_axi_rdata_out[3] == ($past(rx_fill_count_in) != 8'h00))
    else $error("rx nonempty flag wrong");
  busy_flag_a: assert property (st_rd && core_busy_in
    && $past(core_busy_in) && $past(rst_n_in) |=> s_axi_rdata_out[0])
    else $error("busy flag missing");
  rx_dma_a: assert property (rx_dma_req_out
    |-> $past(rx_fill_count_in) != 8'h00)
    else $error("rx dma request with empty fifo");
  cover property (st_rd);
  cover property (s_axi_bvalid_out && s_axi_bready_in);
  cover property (rx_dma_req_out);
endmodule // sspr_chk

bind sspr_regs sspr_chk #(.ADDR_W(ADDR_W), .IDENT_WORD(IDENT_WORD))
  i_sspr_chk (.clk_sys_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .tx_fill_count_in,
  .rx_fill_count_in, .core_busy_in, .rx_dma_req_out);

// >>> bench/sspr_link_model.sv
`timescale 1ns/1ps
module sspr_link_model (
  input wire logic frame_in,
  output logic link_clk_out
);
  // 160 ns link clock, parked low outside frames; offset keeps it unaligned
  initial begin
    link_clk_out = 1'h0;
    #3;
    forever begin
      #80;
      link_clk_out = frame_in ? ~link_clk_out : 1'h0;
    end
  end
endmodule // sspr_link_model

// >>> bench/tb_sspr_regs.sv
`timescale 1ns/1ps
`include "sspr_consts.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  miscompares++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
  $time, (a), (b)); end end
module tb_sspr_regs;
  localparam logic [31:0] ID_W = 32'h0000_0C3C; // arbitrary value
  localparam logic [31:0] VER_W = 32'h0000_0102; // arbitrary value
  localparam logic [1:0] OK = `SSPR_RESP_OKAY;
  localparam logic [1:0] ERR = `SSPR_RESP_SLVERR;
  localparam logic [7:0] ADR [11] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
    8'h2C, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h5C};
  localparam logic [31:0] MSK [11] = '{32'hFFFF, 32'hFF, 32'hFF, 32'h0,
    32'h0, 32'h3F, 32'h3, 32'hFF, 32'hFF, 32'h0, 32'h0};
  localparam logic [31:0] FIX [11] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, ID_W, VER_W};
  localparam logic [7:0] ACK [4] = '{8'h38, 8'h3C, 8'h40, 8'h44};
  localparam logic [31:0] REM [4] = '{32'h2C, 32'h24, 32'h20, 32'h00};
  localparam logic [7:0] TXF [3] = '{8'h04, 8'h05, 8'h00};
  localparam logic [7:0] RXF [3] = '{8'h03, 8'h02, 8'h10};
  localparam logic [1:0] DRQ [3] = '{2'h3, 2'h0, 2'h3};
  logic clk_sys_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00, tx_fill = 8'h01, rx_fill = 8'h00;
  logic [31:0] w_d = 32'h0;
  logic aw_v = 1'h0, w_v = 1'h0, b_rdy = 1'h0, ar_v = 1'h0, r_rdy = 1'h0;
  logic busy = 1'h0, coll = 1'h0, txerr = 1'h0, frame = 1'h0;
  logic [3:0] evt = 4'h0; // tx ovf, rx ovf, rx unf, contention
  wire aw_r, w_r, b_v, ar_r, r_v, link_clk, sclk, irq, tx_req, rx_req;
  wire [1:0] b_resp, r_resp;
  wire [31:0] r_data;
  int miscompares = 0;
  int comparisons = 0;

  // free-running system clock
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  sspr_regs #(.IDENT_WORD(ID_W), .VERSION_WORD(VER_W)) i_sspr_regs (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_r), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_r),
    .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v),
    .s_axi_bready_in(b_rdy), .s_axi_araddr_in(ar_a),
    .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_r),
    .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
    .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_rdy),
    .tx_fill_count_in(tx_fill), .rx_fill_count_in(rx_fill),
    .core_busy_in(busy), .collision_error_in(coll),
    .transmission_error_in(txerr), .tx_overflow_evt_in(evt[0]),
    .rx_overflow_evt_in(evt[1]), .rx_underflow_evt_in(evt[2]),
    .contention_evt_in(evt[3]), .link_clk_in(link_clk), .sclk_out(sclk),
    .irq_out(irq), .tx_dma_req_out(tx_req), .rx_dma_req_out(rx_req));

  sspr_link_model i_sspr_link_model (.frame_in(frame),
    .link_clk_out(link_clk));

  task automatic test_done();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_rdy <= 1'h1;
    do begin
      @(posedge clk_sys_in);
      n++;
      if (aw_r) aw_v <= 1'h0;
      if (w_r) w_v <= 1'h0;
    end while (b_v !== 1'h1 && n < 50);
    b_rdy <= 1'h0;
    `CHK(b_v, 1'h1)
    `CHK(b_resp, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    ar_a <= a;
    ar_v <= 1'h1;
    r_rdy <= 1'h1;
    do begin
      @(posedge clk_sys_in);
      n++;
      if (ar_r) ar_v <= 1'h0;
    end while (r_v !== 1'h1 && n < 50);
    r_rdy <= 1'h0;
    `CHK(r_v, 1'h1)
    `CHK(r_data, e)
    `CHK(r_resp, er)
  endtask

  // one-cycle event strobe
  task automatic pulse(input logic [3:0] e);
    @(posedge clk_sys_in);
    evt <= e;
    @(posedge clk_sys_in);
    evt <= 4'h0;
  endtask

  // main sequence
  initial begin
    int n;
    logic s;
    logic hi;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    for (int i = 0; i < 11; i++) begin
      rd(ADR[i], FIX[i], OK);
      wr(ADR[i], 32'hFFFFFFFF, OK);
      rd(ADR[i], FIX[i] | MSK[i], OK);
      wr(ADR[i], 32'h0, OK);
    end
    wr(8'h00, 32'h1, ERR);
    rd(8'h60, 32'h0, ERR);
    // every status flag raised, then every one dropped
    tx_fill <= 8'h00;
    rx_fill <= 8'h10;
    busy <= 1'h1;
    coll <= 1'h1;
    txerr <= 1'h1;
    rd(8'h28, 32'h7F, OK);
    tx_fill <= 8'h10;
    rx_fill <= 8'h00;
    busy <= 1'h0;
    coll <= 1'h0;
    txerr <= 1'h0;
    tick(40);
    rd(8'h28, 32'h00, OK);
    // link clock activity alone keeps busy up for the idle window
    frame <= 1'h1;
    tick(30);
    rd(8'h28, 32'h01, OK);
    frame <= 1'h0;
    tick(45);
    rd(8'h28, 32'h00, OK);
    // sticky events, then one ack at a time
    wr(8'h2C, 32'h3F, OK);
    pulse(4'hF);
    rd(8'h34, 32'h2E, OK);
    rd(8'h30, 32'h2E, OK);
    `CHK(irq, 1'h1)
    for (int i = 0; i < 4; i++) begin
      rd(ACK[i], 32'h1, OK);
      rd(ACK[i], 32'h0, OK);
      rd(8'h34, REM[i], OK);
    end
    tick(2);
    `CHK(irq, 1'h0)
    // masked-off source stays out of the line
    wr(8'h2C, 32'h00, OK);
    pulse(4'h1);
    rd(8'h34, 32'h02, OK);
    rd(8'h30, 32'h00, OK);
    `CHK(irq, 1'h0)
    pulse(4'hF);
    rd(8'h48, 32'h1, OK);
    rd(8'h34, 32'h0, OK);
    // level sources survive the combined ack
    rx_fill <= 8'h01;
    wr(8'h18, 32'h10, OK);
    wr(8'h2C, 32'h11, OK);
    rd(8'h48, 32'h0, OK);
    rd(8'h34, 32'h11, OK);
    rd(8'h30, 32'h11, OK);
    `CHK(irq, 1'h1)
    wr(8'h2C, 32'h00, OK);
    // dma requests at the watermark boundaries
    wr(8'h4C, 32'h3, OK);
    wr(8'h50, 32'h4, OK);
    wr(8'h54, 32'h2, OK);
    for (int i = 0; i < 3; i++) begin
      tx_fill <= TXF[i];
      rx_fill <= RXF[i];
      tick(3);
      `CHK({tx_req, rx_req}, DRQ[i])
    end
    // divisor four toggles every two cycles, zero parks low
    wr(8'h14, 32'h4, OK);
    tick(10);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      s = sclk;
      while (sclk === s && n < 20) begin
        @(posedge clk_sys_in);
        n++;
      end
    end
    `CHK(n, 2)
    wr(8'h14, 32'h0, OK);
    tick(4);
    hi = 1'h0;
    repeat (16) begin
      @(posedge clk_sys_in);
      hi = hi | sclk;
    end
    `CHK(hi, 1'h0)
    test_done();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #500000;
    miscompares++;
    test_done();
  end
endmodule // tb_sspr_regs
